// ===== design/can_mode_ctrl.sv
// Purpose: mode, listen-only, auxiliary and fail-safe logic of an isolated CAN transceiver
// Assumes: pins asynchronous to clk_i; slope/standby level arrives pre-quantised on two bits
// Notes: registers over classic Wishbone; one level interrupt from masked sticky events
`timescale 1ns/1ps
// Summary of operation
// - listen-only masks transmit input and keeps the bus recessive
// - receive path forwards bus state unchanged during listen-only
// - slope/standby select decodes to exactly one of three modes
// - standby select filters fast data and biases bus lines to ground
// - standby select touches only the transceiver, not channels or auxiliary
// - auxiliary output changes no faster than 40 kbps while not low power
// - low-power request freezes auxiliary output at its current level
// - standby heartbeat pulses stay narrower than 25 us
// - undriven transmit input reads as recessive high
// - transmit low beyond the limit stops dominant drive
// - tripped timeout clears only when transmit returns high
// - die over temperature disables drivers until cooled
// - recessive is logic high, dominant logic low on transmit and receive
// - low-power request disables transmit and tri-states the driver
// - in standby receive only after wake pattern, until standby exits
module can_mode_ctrl
  import can_xcvr_pkg::*;
#(
  parameter int unsigned DT_CYC = DOMINANT_LIMIT_NS / CLK_NS,
  parameter int unsigned HB_PERIOD_CYC = HB_PERIOD_NS / CLK_NS,
  parameter int unsigned WAKE_WINDOW_CYC = WAKE_WINDOW_NS / CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  input wire logic txd_i,
  input wire logic txd_driven_i,
  input wire logic listen_only_i,
  input wire logic low_power_request_i,
  input wire logic [1:0] slope_standby_select_i,
  input wire logic aux_i,
  input wire logic bus_rx_i,
  input wire logic over_temp_i,
  output logic rxd_o,
  output logic bus_dominant_o,
  output logic driver_en_o,
  output logic bias_ground_o,
  output logic slope_ctrl_o,
  output logic aux_o,
  output logic shared_pulse_o
);
  // decode of the quantised select level, used by state and status
  function automatic mode_t decode_mode(input logic [1:0] lvl);
    if (lvl[1]) begin
      return MODE_LOW_POWER_REQUEST;
    end else if (lvl[0]) begin
      return MODE_SLOPE;
    end else begin
      return MODE_FAST;
    end
  endfunction

  // two-flop synchronisers, first stage read only by the second
  logic [PIN_W-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {over_temp_i, bus_rx_i, aux_i, slope_standby_select_i,
                    low_power_request_i, listen_only_i, txd_driven_i, txd_i};
  for (genvar g = 0; g < PIN_W; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync1_q[g] <= PIN_IDLE[g];
        sync2_q[g] <= PIN_IDLE[g];
      end else if (ce_i) begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  // effective levels after synchronisation
  logic ctrl_listen, ctrl_lowpwr;
  logic txd_eff, listen, lowpwr, hot, bus_rx, tripped, sss_low_power_request, rx_standby;
  mode_t mode;
  assign txd_eff = sync2_q[PIN_TXD] | ~sync2_q[PIN_TXD_DRIVEN];
  assign listen = sync2_q[PIN_LISTEN] | ctrl_listen;
  assign lowpwr = sync2_q[PIN_LOWPWR] | ctrl_lowpwr;
  assign hot = sync2_q[PIN_HOT];
  assign bus_rx = sync2_q[PIN_BUS_RX];
  assign mode = decode_mode(sync2_q[PIN_SSS_HI:PIN_SSS_LO]);
  assign sss_low_power_request = (mode == MODE_LOW_POWER_REQUEST);
  assign rx_standby = lowpwr | sss_low_power_request;

  dominant_timer #(
    .DT_CYC(DT_CYC)
  ) u_dt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .txd_i(txd_eff),
    .tripped_o(tripped)
  );

  // wake pattern detector: dominant, recessive, dominant phases inside a window
  wake_t wake_q, wake_d;
  logic [15:0] run_q, run_d;
  logic [31:0] win_q, win_d;
  logic rx_prev_q, rx_prev_d;
  logic phase_ok;
  // the level now seen must itself have held, not the phase before it
  assign phase_ok = (bus_rx == rx_prev_q) && (run_q >= 16'(WAKE_PHASE_CYC - 1));
  always_comb begin
    wake_d = wake_q;
    rx_prev_d = bus_rx;
    run_d = (bus_rx != rx_prev_q) ? 16'h0 : ((run_q == 16'hffff) ? run_q : run_q + 16'h1);
    win_d = (wake_q == WAKE_IDLE || wake_q == WAKE_AWAKE) ? 32'h0 : win_q + 32'h1;
    case (wake_q)
      WAKE_IDLE: begin
        if (!bus_rx && phase_ok) begin
          wake_d = WAKE_DOM;
        end
      end
      WAKE_DOM: begin
        if (win_q >= WAKE_WINDOW_CYC - 1) begin
          wake_d = WAKE_IDLE;
        end else if (bus_rx && phase_ok) begin
          wake_d = WAKE_REC;
        end
      end
      WAKE_REC: begin
        if (win_q >= WAKE_WINDOW_CYC - 1) begin
          wake_d = WAKE_IDLE;
        end else if (!bus_rx && phase_ok) begin
          wake_d = WAKE_AWAKE;
        end
      end
      WAKE_AWAKE: wake_d = WAKE_AWAKE; // pattern alone never leaves standby
      default: wake_d = WAKE_IDLE;
    endcase
    if (!rx_standby) begin
      wake_d = WAKE_IDLE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_q <= WAKE_IDLE;
      run_q <= 16'h0;
      win_q <= 32'h0;
      rx_prev_q <= 1'b1;
    end else if (ce_i) begin
      wake_q <= wake_d;
      run_q <= run_d;
      win_q <= win_d;
      rx_prev_q <= rx_prev_d;
    end
  end

  // transceiver side outputs, all registered
  logic rxd_q, rxd_d, dom_q, dom_d, drv_q, drv_d, bias_q, bias_d, slope_q, slope_d;
  always_comb begin
    // listen-only, low power, timeout, heat and standby all force recessive
    dom_d = ~txd_eff & ~listen & ~lowpwr & ~tripped & ~hot & ~sss_low_power_request;
    drv_d = ~lowpwr & ~hot & ~sss_low_power_request;
    bias_d = rx_standby;
    slope_d = (mode == MODE_SLOPE);
    // receive path ignores listen-only; standby passes data only once woken
    rxd_d = (rx_standby && wake_q != WAKE_AWAKE) ? 1'b1 : bus_rx;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_q <= 1'b1;
      dom_q <= 1'b0;
      drv_q <= 1'b0;
      bias_q <= 1'b0;
      slope_q <= 1'b0;
    end else if (ce_i) begin
      rxd_q <= rxd_d;
      dom_q <= dom_d;
      drv_q <= drv_d;
      bias_q <= bias_d;
      slope_q <= slope_d;
    end
  end

  // auxiliary channel and standby heartbeat share one path
  logic aux_q, aux_d, hb_q, hb_d;
  logic [31:0] aux_cnt_q, aux_cnt_d, hb_cnt_q, hb_cnt_d;
  always_comb begin
    aux_d = aux_q;
    aux_cnt_d = (aux_cnt_q == 32'h0) ? aux_cnt_q : aux_cnt_q - 32'h1;
    hb_cnt_d = 32'h0;
    hb_d = 1'b0;
    if (lowpwr) begin
      // aux frozen, path now carries the heartbeat; select pin plays no part
      hb_cnt_d = (hb_cnt_q >= HB_PERIOD_CYC - 1) ? 32'h0 : hb_cnt_q + 32'h1;
      hb_d = (hb_cnt_d < HB_WIDTH_CYC);
    end else if (aux_cnt_q == 32'h0 && sync2_q[PIN_AUX] != aux_q) begin
      // rate limit keeps the shared path free of faster data
      aux_d = sync2_q[PIN_AUX];
      aux_cnt_d = AUX_BIT_CYC - 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_q <= 1'b0;
      hb_q <= 1'b0;
      aux_cnt_q <= 32'h0;
      hb_cnt_q <= 32'h0;
    end else if (ce_i) begin
      aux_q <= aux_d;
      hb_q <= hb_d;
      aux_cnt_q <= aux_cnt_d;
      hb_cnt_q <= hb_cnt_d;
    end
  end

  // wishbone slave, control, sticky interrupts and mask
  logic [1:0] ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic ack_q, ack_d, irq_q, irq_d;
  logic [31:0] dat_q, dat_d;
  logic trip_prev_q, hot_prev_q, low_power_request_prev_q;
  logic wr;
  assign ctrl_listen = ctrl_q[CTRL_LISTEN_BIT];
  assign ctrl_lowpwr = ctrl_q[CTRL_LOWPWR_BIT];
  assign wr = cyc_i & stb_i & we_i & ~ack_q & sel_i[0];
  assign ev[IRQ_TRIP_BIT] = tripped & ~trip_prev_q;
  assign ev[IRQ_HOT_BIT] = hot & ~hot_prev_q;
  assign ev[IRQ_WAKE_BIT] = (wake_d == WAKE_AWAKE) & (wake_q != WAKE_AWAKE);
  assign ev[IRQ_LOW_POWER_REQUEST_BIT] = rx_standby & ~low_power_request_prev_q;
  always_comb begin
    ack_d = cyc_i & stb_i & ~ack_q;
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q;
    dat_d = 32'h0;
    if (wr && adr_i == CTRL_OFS) begin
      ctrl_d = dat_i[1:0];
    end
    if (wr && adr_i == IRQ_MASK_OFS) begin
      imask_d = dat_i[IRQ_W-1:0];
    end
    if (wr && adr_i == IRQ_STAT_OFS) begin
      ist_d = ist_q & ~dat_i[IRQ_W-1:0];
    end
    ist_d = ist_d | ev; // a new event beats a same-cycle clear
    case (adr_i)
      CTRL_OFS: dat_d[1:0] = ctrl_q;
      STAT_OFS: begin
        dat_d[STAT_RX_BIT] = rxd_q;
        dat_d[STAT_TRIP_BIT] = tripped;
        dat_d[STAT_HOT_BIT] = hot;
        dat_d[STAT_WOKEN_BIT] = (wake_q == WAKE_AWAKE);
        dat_d[STAT_LOW_POWER_REQUEST_BIT] = rx_standby;
        dat_d[STAT_MODE_LSB+1:STAT_MODE_LSB] = mode;
      end
      IRQ_STAT_OFS: dat_d[IRQ_W-1:0] = ist_q;
      IRQ_MASK_OFS: dat_d[IRQ_W-1:0] = imask_q;
      default: dat_d = 32'h0; // unmapped reads zero, writes dropped
    endcase
    irq_d = |(ist_d & imask_d);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      imask_q <= IRQ_RESET;
      ist_q <= IRQ_RESET;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      irq_q <= 1'b0;
      trip_prev_q <= 1'b0;
      hot_prev_q <= 1'b0;
      low_power_request_prev_q <= 1'b0;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
      trip_prev_q <= tripped;
      hot_prev_q <= hot;
      low_power_request_prev_q <= rx_standby;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign irq_o = irq_q;
  assign rxd_o = rxd_q;
  assign bus_dominant_o = dom_q;
  assign driver_en_o = drv_q;
  assign bias_ground_o = bias_q;
  assign slope_ctrl_o = slope_q;
  assign aux_o = aux_q;
  assign shared_pulse_o = hb_q;

  // checks
  a_listen_recessive: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && listen) |=> !bus_dominant_o)
    else $error("dominant driven in listen-only");
  a_listen_rx_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && listen && !rx_standby) |=> (rxd_o == $past(bus_rx)))
    else $error("receive path altered in listen-only");
  a_standby_bias: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sss_low_power_request) |=> (bias_ground_o && !driver_en_o))
    else $error("standby select did not bias lines");
  a_aux_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    (lowpwr && $past(lowpwr)) |-> $stable(aux_o))
    else $error("aux output moved in low power");
  // helper: cycles the heartbeat has stood high so far, too long for a delay range
  logic [31:0] hb_run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hb_run_q <= 32'h0;
    end else if (ce_i) begin
      hb_run_q <= shared_pulse_o ? hb_run_q + 32'h1 : 32'h0;
    end
  end
  a_pulse_narrow: assert property (@(posedge clk_i) disable iff (rst_i)
    shared_pulse_o |-> (hb_run_q < HB_MAX_NS / CLK_NS - 1))
    else $error("heartbeat pulse too wide");
  a_float_recessive: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !sync2_q[PIN_TXD_DRIVEN]) |=> !bus_dominant_o)
    else $error("floating transmit produced dominant");
  a_hot_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && hot) |=> !driver_en_o)
    else $error("driver enabled while over temperature");
  a_lowpwr_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && lowpwr) |=> (!driver_en_o && !bus_dominant_o))
    else $error("transmitter active in low power");
  a_standby_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rx_standby && wake_q != WAKE_AWAKE) |=> rxd_o)
    else $error("receive passed before wake pattern");
  a_timeout_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && tripped) |=> !bus_dominant_o)
    else $error("dominant after timeout");
  c_wake_seen: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wake_q == WAKE_AWAKE));
  c_timeout_trip: cover property (@(posedge clk_i) disable iff (rst_i) $rose(tripped));
  c_heartbeat: cover property (@(posedge clk_i) disable iff (rst_i) $fell(shared_pulse_o));
endmodule

// ===== design/can_xcvr_pkg.sv
// Purpose: shared constants and types for the CAN transceiver mode control block
// Assumes: 50 MHz system clock, classic Wishbone register access
// Notes: every offset, bit position and field reset value lives here, with the timing figures the cycle counts derive from
package can_xcvr_pkg;
  // clock
  localparam int unsigned CLK_NS = 20;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // control fields
  localparam int unsigned CTRL_LISTEN_BIT = 0;
  localparam int unsigned CTRL_LOWPWR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int unsigned STAT_RX_BIT = 0;
  localparam int unsigned STAT_TRIP_BIT = 1;
  localparam int unsigned STAT_HOT_BIT = 2;
  localparam int unsigned STAT_WOKEN_BIT = 3;
  localparam int unsigned STAT_LOW_POWER_REQUEST_BIT = 4;
  localparam int unsigned STAT_MODE_LSB = 5;
  // interrupt fields, same layout in status and mask
  localparam int unsigned IRQ_TRIP_BIT = 0;
  localparam int unsigned IRQ_HOT_BIT = 1;
  localparam int unsigned IRQ_WAKE_BIT = 2;
  localparam int unsigned IRQ_LOW_POWER_REQUEST_BIT = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // pin synchroniser lanes
  localparam int unsigned PIN_TXD = 0;
  localparam int unsigned PIN_TXD_DRIVEN = 1;
  localparam int unsigned PIN_LISTEN = 2;
  localparam int unsigned PIN_LOWPWR = 3;
  localparam int unsigned PIN_SSS_LO = 4;
  localparam int unsigned PIN_SSS_HI = 5;
  localparam int unsigned PIN_AUX = 6;
  localparam int unsigned PIN_BUS_RX = 7;
  localparam int unsigned PIN_HOT = 8;
  localparam int unsigned PIN_W = 9;
  // synchroniser reset levels follow each pin's idle state, so no false edge follows reset
  localparam logic [PIN_W-1:0] PIN_IDLE = 9'h083;
  // timing: standby heartbeat pulse must stay narrower than this
  localparam int unsigned HB_MAX_NS = 25000;
  localparam int unsigned HB_WIDTH_CYC = HB_MAX_NS / CLK_NS - 1;
  localparam int unsigned HB_PERIOD_NS = 1000000;
  // timing: auxiliary channel, 20 kHz square wave = 40 kbps nrz
  localparam int unsigned AUX_MAX_HZ = 20000;
  localparam int unsigned AUX_BIT_NS = 1000000000 / (2 * AUX_MAX_HZ);
  localparam int unsigned AUX_BIT_CYC = (AUX_BIT_NS + CLK_NS - 1) / CLK_NS;
  // timing: dominant limit, wake pattern phase and window
  localparam int unsigned DOMINANT_LIMIT_NS = 1000000;
  localparam int unsigned WAKE_PHASE_NS = 500;
  localparam int unsigned WAKE_PHASE_CYC = (WAKE_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_WINDOW_NS = 1000000;
  // slope/standby select decode
  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_SLOPE = 2'b01,
    MODE_LOW_POWER_REQUEST = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b00,
    WAKE_DOM = 2'b01,
    WAKE_REC = 2'b10,
    WAKE_AWAKE = 2'b11
  } wake_t;
endpackage

// ===== design/dominant_timer.sv
// Purpose: dominant timeout watchdog on the synchronised transmit level
// Assumes: txd_i already synchronised to clk_i, low means dominant
// Notes: trip holds until the transmit level returns high
`timescale 1ns/1ps
module dominant_timer
  import can_xcvr_pkg::*;
#(
  parameter int unsigned DT_CYC = 50000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic txd_i,
  output logic tripped_o
);
  logic [31:0] cnt_q, cnt_d;
  logic trip_q, trip_d;

  // count low time, trip at the limit, release only on a high level
  always_comb begin
    cnt_d = cnt_q;
    trip_d = trip_q;
    if (txd_i) begin
      cnt_d = 32'h0;
      trip_d = 1'b0;
    end else if (cnt_q >= DT_CYC - 1) begin
      trip_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      trip_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      trip_q <= trip_d;
    end
  end

  assign tripped_o = trip_q;

  a_trip_needs_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(trip_q) |-> !$past(txd_i))
    else $error("timeout tripped without a low transmit level");
  a_resume_on_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && txd_i) |=> !trip_q)
    else $error("timeout not released by high transmit level");
  a_trip_at_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !txd_i && cnt_q == DT_CYC - 1) |=> trip_q)
    else $error("timeout did not trip at the limit");
endmodule

// ===== bench/can_ctrl_model.sv
// Purpose: logic-side protocol controller model driving the transmit pin
// Assumes: one bit lasts BIT_CYC clocks; recessive is high
// Notes: sends one dominant run per request, no frame content
`timescale 1ns/1ps
module can_ctrl_model #(
  parameter int unsigned BIT_CYC = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [3:0] dom_bits_i,
  input wire logic lowpwr_i,
  output logic txd_o,
  output logic busy_o
);
  int unsigned left = 0;
  // txd held recessive around low power, so no run straddles entry or exit
  always @(posedge clk_i) begin
    if (rst_i || lowpwr_i) begin
      left <= 0;
      txd_o <= 1'b1;
    end else if (left != 0) begin
      left <= left - 1;
      txd_o <= (left == 1);
    end else if (send_i) begin
      // runs capped at eleven bits: six error bits plus echoed flags
      left <= ((dom_bits_i > 4'd11) ? 4'd11 : dom_bits_i) * BIT_CYC;
      txd_o <= 1'b0;
    end
  end
  assign busy_o = (left != 0);
endmodule

// ===== bench/can_transceiver_mode_control_tb.sv
// Purpose: self-checking bench for the transceiver mode control block
// Assumes: shortened dominant limit and heartbeat period via parameters
// Notes: registers reached over classic Wishbone single cycles
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module can_transceiver_mode_control_tb;
  import can_xcvr_pkg::*;
  localparam int unsigned HB_LIM = HB_MAX_NS / CLK_NS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, nbits = 4'h0;
  logic [31:0] wdat = 32'h0, d;
  logic tb_txd = 1'b1, txd_driven = 1'b1, listen = 1'b0, lowpwr = 1'b0, aux_i = 1'b0, bus_rx = 1'b1, hot = 1'b0;
  logic [1:0] sss = 2'h0;
  logic [31:0] dat_o;
  logic ack_o, irq_o, rxd_o, bus_dominant_o, driver_en_o, bias_ground_o, slope_ctrl_o, aux_o, shared_pulse_o;
  logic m_txd, aux_last = 1'b0;
  int fails = 0, num_checks = 0, cycles = 0, gap = 0, hb_w = 0, hb_cnt = 0;
  always #10 clk_i = ~clk_i;
  can_mode_ctrl #(.DT_CYC(20), .HB_PERIOD_CYC(1400), .WAKE_WINDOW_CYC(200)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .txd_i(m_txd & tb_txd),
    .txd_driven_i(txd_driven), .listen_only_i(listen), .low_power_request_i(lowpwr),
    .slope_standby_select_i(sss), .aux_i(aux_i), .bus_rx_i(bus_rx), .over_temp_i(hot), .rxd_o(rxd_o),
    .bus_dominant_o(bus_dominant_o), .driver_en_o(driver_en_o), .bias_ground_o(bias_ground_o),
    .slope_ctrl_o(slope_ctrl_o), .aux_o(aux_o), .shared_pulse_o(shared_pulse_o));
  can_ctrl_model #(.BIT_CYC(1)) model_u (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .dom_bits_i(nbits),
    .lowpwr_i(lowpwr), .txd_o(m_txd), .busy_o());
  task end_sim;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog; a hang ends in the same verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] timeout exp %0d got %0d", 20000, cycles);
      end_sim();
    end
  end
  // aux spacing and heartbeat width, sampled mid-cycle where outputs are settled
  always @(negedge clk_i) begin
    if (!rst_i && aux_o !== aux_last) begin
      if (gap > 0) `CHK("aux gap", 1'b1, gap >= AUX_BIT_CYC)
      gap = 1;
      aux_last = aux_o;
    end else if (gap > 0) gap++;
    if (shared_pulse_o === 1'b1) hb_w++;
    else if (hb_w > 0) begin
      `CHK("pulse width", 1'b1, hb_w < HB_LIM)
      hb_cnt++;
      hb_w = 0;
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one classic cycle; waits for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= v;
    // ack seen just after an edge is what the next edge samples
    do begin
      @(posedge clk_i);
      #1;
    end while (ack_o !== 1'b1);
    d = dat_o;
    @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic burst(input logic [3:0] n, input logic exp);
    @(posedge clk_i);
    nbits <= n;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    wt(4);
    `CHK("dominant drive", exp, bus_dominant_o)
    wt(n + 4);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(6);
    `CHK("rxd idle", 1'b1, rxd_o)
    `CHK("driver on", 1'b1, driver_en_o)
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", CTRL_RESET, d[1:0])
    wb(1'b0, IRQ_MASK_OFS, 32'h0);
    `CHK("mask reset", IRQ_RESET, d[3:0])
    wb(1'b1, 8'h20, 32'hff);
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, d)
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl rw", 2'h1, d[1:0])
    burst(4'd6, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0);
    burst(4'd6, 1'b1);
    burst(4'd11, 1'b1);
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("no trip", 1'b0, d[STAT_TRIP_BIT])
    // listen-only pin with a stuck-low transmit
    @(posedge clk_i);
    listen <= 1'b1;
    tb_txd <= 1'b0;
    bus_rx <= 1'b0;
    wt(5);
    `CHK("listen bus", 1'b0, bus_dominant_o)
    `CHK("listen rxd", 1'b0, rxd_o)
    @(posedge clk_i);
    bus_rx <= 1'b1;
    wt(5);
    `CHK("listen rxd", 1'b1, rxd_o)
    @(posedge clk_i);
    listen <= 1'b0;
    tb_txd <= 1'b1;
    wt(5);
    wb(1'b1, IRQ_STAT_OFS, 32'hf);
    wb(1'b1, IRQ_MASK_OFS, 32'h1 << IRQ_TRIP_BIT);
    // shorted transmit line trips the dominant limit
    @(posedge clk_i);
    tb_txd <= 1'b0;
    wt(5);
    `CHK("dominant", 1'b1, bus_dominant_o)
    wt(25);
    `CHK("timeout", 1'b0, bus_dominant_o)
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("trip flag", 1'b1, d[STAT_TRIP_BIT])
    `CHK("irq", 1'b1, irq_o)
    wb(1'b1, IRQ_MASK_OFS, 32'h0);
    wt(3);
    `CHK("irq masked", 1'b0, irq_o)
    wb(1'b1, IRQ_MASK_OFS, 32'h1 << IRQ_TRIP_BIT);
    wt(3);
    `CHK("irq unmasked", 1'b1, irq_o)
    @(posedge clk_i);
    tb_txd <= 1'b1;
    wt(5);
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("trip clear", 1'b0, d[STAT_TRIP_BIT])
    wb(1'b1, IRQ_STAT_OFS, 32'h1 << IRQ_TRIP_BIT);
    wt(3);
    `CHK("irq cleared", 1'b0, irq_o)
    burst(4'd6, 1'b1);
    // floating transmit pin reads recessive
    @(posedge clk_i);
    txd_driven <= 1'b0;
    tb_txd <= 1'b0;
    wt(6);
    `CHK("float", 1'b0, bus_dominant_o)
    @(posedge clk_i);
    txd_driven <= 1'b1;
    tb_txd <= 1'b1;
    hot <= 1'b1;
    wt(5);
    `CHK("hot off", 1'b0, driver_en_o)
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("hot flag", 1'b1, d[STAT_HOT_BIT])
    @(posedge clk_i);
    hot <= 1'b0;
    wt(5);
    `CHK("cooled", 1'b1, driver_en_o)
    // each select level: fast, slope, standby
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_i);
      sss <= m[1:0];
      wt(5);
      wb(1'b0, STAT_OFS, 32'h0);
      `CHK("mode", m[1:0], d[STAT_MODE_LSB +: 2])
      `CHK("slope", (m == 1), slope_ctrl_o)
      `CHK("bias", (m == 2), bias_ground_o)
    end
    @(posedge clk_i);
    bus_rx <= 1'b0;
    aux_i <= 1'b1;
    wt(5);
    `CHK("low_power_request filter", 1'b1, rxd_o)
    @(posedge clk_i);
    bus_rx <= 1'b1;
    wt(AUX_BIT_CYC + 10);
    `CHK("aux in low_power_request", 1'b1, aux_o)
    // wake pattern: dominant, recessive, dominant, each phase well over the minimum
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      bus_rx <= k[0];
      wt(40);
    end
    `CHK("woken rxd", 1'b0, rxd_o)
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("woken flag", 1'b1, d[STAT_WOKEN_BIT])
    `CHK("still low_power_request", 1'b1, d[STAT_LOW_POWER_REQUEST_BIT])
    @(posedge clk_i);
    bus_rx <= 1'b1;
    @(posedge clk_i);
    sss <= 2'h0;
    lowpwr <= 1'b1;
    wt(4);
    @(posedge clk_i);
    aux_i <= 1'b0;
    wt(3000);
    `CHK("aux held", 1'b1, aux_o)
    `CHK("lp driver", 1'b0, driver_en_o)
    `CHK("lp bus", 1'b0, bus_dominant_o)
    `CHK("pulses", 1'b1, hb_cnt > 0)
    @(posedge clk_i);
    lowpwr <= 1'b0;
    wt(AUX_BIT_CYC + 10);
    `CHK("aux resumed", 1'b0, aux_o)
    `CHK("lp exit", 1'b1, driver_en_o)
    // low power forced from the control register
    wb(1'b1, CTRL_OFS, 32'h1 << CTRL_LOWPWR_BIT);
    wt(2);
    `CHK("ctrl lp", 1'b0, driver_en_o)
    wb(1'b0, STAT_OFS, 32'h0);
    `CHK("ctrl lp low_power_request", 1'b1, d[STAT_LOW_POWER_REQUEST_BIT])
    wb(1'b1, CTRL_OFS, 32'h0);
    end_sim();
  end
endmodule
